// >>> hdl/wdt_top.sv
// watchdog reset timer: service location on the cpu bus, counting chain, reset driver
// assumes clk_sys_in is the oscillator clock and rst_in is the power-on reset
// assumes bus, mode and configuration inputs are synchronous to clk_sys_in
`default_nettype none
// Summary of operation
// R1: 12-bit prescaler drives 6-bit counter
// R2: overflow after 2^18-2^4 or 2^13-2^4 cycles
// R3: rate select 1 short, 0 long
// R4: any write to service clears counter, prescaler stages 12..5
// R5: service read returns reset vector low byte
// R6: reset drives pin low 32 cycles, sets flag
// R7: stop instruction clears prescaler
// R8: prescaler cleared 4096 cycles after power-up
// R9: internal reset clears prescaler and counter
// R10: reset vector fetch clears prescaler
// R11: disable input 1 turns watchdog off
// R12: monitor with test voltage holds watchdog off
// R13: blank-vector monitor entry disables until power-on
// R14: break plus reset-pin test voltage disables
// R15: wait mode keeps counting and resetting
// R16: stop mode gates clock, clears prescaler
// R17: stop while disallowed gives illegal-opcode reset
// R18: stop enable 1 allows, 0 illegal
// R19: never raises a cpu interrupt
// R20: counter steps on carry, overflow synchronous
module wdt_top #(
   parameter int POR_CLR_CYCLES = wdt_pkg::WDT_POR_CLR_CYCLES,
   parameter int RST_PIN_CYCLES = wdt_pkg::WDT_RST_PIN_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // cpu bus
   input wire logic [wdt_pkg::WDT_ADDR_W-1:0] bus_addr_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic [wdt_pkg::WDT_DATA_W-1:0] bus_wdata_in,
   input wire logic [wdt_pkg::WDT_DATA_W-1:0] reset_vector_low_in,
   output logic [wdt_pkg::WDT_DATA_W-1:0] bus_rdata_out,
   output logic bus_rdata_valid_out,
   // configuration bits
   input wire logic timeout_rate_select_in,
   input wire logic watchdog_disable_in,
   input wire logic stop_enable_in,
   // cpu and system events
   input wire logic stop_exec_in,
   input wire logic stop_mode_in,
   input wire logic wait_mode_in,
   input wire logic vector_fetch_in,
   input wire logic internal_reset_in,
   input wire logic cause_flag_clear_in,
   // monitor and break
   input wire logic monitor_mode_in,
   input wire logic monitor_via_irq_in,
   input wire logic irq_test_high_voltage_in,
   input wire logic rst_pin_test_high_voltage_in,
   input wire logic break_active_in,
   // reset outputs
   output logic reset_pin_low_out,
   output logic chip_reset_req_out,
   output logic watchdog_cause_flag_out,
   output logic illegal_opcode_reset_out,
   output logic stop_entry_out,
   output logic [wdt_pkg::WDT_CNT_W-1:0] count_out
);
   // registered state; every next_ value is computed in an always_comb
   // and only copied in the single always_ff at the end of the module
   // por_cnt is sized for the default settle time, not for a shortened one
   wdt_pkg::wdt_state_t state;
   wdt_pkg::wdt_state_t next_state;
   logic [wdt_pkg::WDT_POR_W-1:0] por_cnt;
   logic [wdt_pkg::WDT_POR_W-1:0] next_por_cnt;
   logic blank_monitor_off;
   logic next_blank_monitor_off;
   logic cause_flag;
   logic next_cause_flag;
   logic [wdt_pkg::WDT_DATA_W-1:0] rdata;
   logic [wdt_pkg::WDT_DATA_W-1:0] next_rdata;
   logic rdata_valid;
   logic next_rdata_valid;
   logic illegal;
   logic next_illegal;
   logic stop_entry;
   logic next_stop_entry;
   logic chip_req;
   logic next_chip_req;
   logic pin_low;
   logic next_pin_low;
   logic [wdt_pkg::WDT_CNT_W-1:0] cnt_q;

   // decode and chain hookup, all combinational
   logic svc_hit;
   logic svc_wr;
   logic svc_rd;
   logic disabled;
   logic run;
   logic clr_all;
   logic clr_pre;
   logic por_done;
   logic overflow;
   logic pulse_active;
   logic timeout;
   logic [wdt_pkg::WDT_CNT_W-1:0] chain_count;

   // address decode, shared by read and write paths
   // full 16-bit compare: the neighbouring vector byte must not service the watchdog
   // the vector fetch arrives as its own strobe, not through this decode
   function automatic logic hits_service(input logic [wdt_pkg::WDT_ADDR_W-1:0] a);
      hits_service = (a == wdt_pkg::WDT_SERVICE_ADDR);
   endfunction

   assign svc_hit = hits_service(bus_addr_in);
   assign svc_wr = bus_wr_in & svc_hit;
   assign svc_rd = bus_rd_in & svc_hit;
   assign por_done = (por_cnt == wdt_pkg::WDT_POR_W'(POR_CLR_CYCLES));

   // a counted timeout only matters while the watchdog is on; a disable that
   // arrives in the overflow cycle itself still suppresses the reset
   // used by the sequencer, the cause flag, the stretcher and the request
   assign timeout = overflow & ~disabled;

   // disable sources; the blank-vector case sticks until the next power-on
   // every source forces the chain clear, so leaving any of them starts a full period
   // monitor disable needs the irq entry and a test voltage on either pin
   always_comb begin
      disabled = watchdog_disable_in; // R11
      if (monitor_mode_in & monitor_via_irq_in &
         (irq_test_high_voltage_in | rst_pin_test_high_voltage_in)) begin
         disabled = 1'b1; // R12
      end
      if (blank_monitor_off) begin
         disabled = 1'b1; // R13
      end
      if (break_active_in & rst_pin_test_high_voltage_in) begin
         disabled = 1'b1; // R14
      end
   end

   // counting is gated in stop mode; wait mode leaves the chain running
   // stop mode is a level from the clock control; the prescaler clears while it stands
   always_comb begin
      run = ~disabled & ~stop_mode_in & (state == wdt_pkg::WDT_ST_RUN); // R15 R16
      // wait mode deliberately has no effect on run
      if (wait_mode_in) begin
         run = ~disabled & ~stop_mode_in & (state == wdt_pkg::WDT_ST_RUN); // R15
      end
      // disabled or resetting holds the chain clear so enabling starts fresh
      clr_all = internal_reset_in | disabled | (state == wdt_pkg::WDT_ST_RESET); // R9 R11
      clr_pre = (stop_exec_in & stop_enable_in) // R7
         | stop_mode_in // R16
         | vector_fetch_in // R10
         | ((state == wdt_pkg::WDT_ST_POR_WAIT) & por_done); // R8
   end

   // long option: 64 carries of the 12-bit prescaler; short option: 2 carries
   // a service keeps prescaler stages 4..1, so the period from a service is
   // shorter than the full count by whatever those stages held
   // rate select is a level; a change mid-period acts at the next carry
   wdt_chain #(
      .PRE_W(wdt_pkg::WDT_PRE_W),
      .CNT_W(wdt_pkg::WDT_CNT_W)
   ) u_chain (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .run_in(run),
      .rate_short_in(timeout_rate_select_in == wdt_pkg::WDT_RATE_SHORT),
      .clr_all_in(clr_all),
      .clr_service_in(svc_wr),
      .clr_pre_in(clr_pre),
      .overflow_out(overflow),
      .count_out(chain_count)
   );

   // the stretcher counts the pin time; the trigger cycle is not part of it,
   // so the pin sees exactly RST_PIN_CYCLES low cycles
   wdt_pulse #(
      .LEN(RST_PIN_CYCLES),
      .W(wdt_pkg::WDT_PULSE_W)
   ) u_pulse (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .trig_in(timeout),
      .active_out(pulse_active)
   );

   // sequencing: power-on wait, normal counting, reset pin drive
   // timeline of a timeout: c0 chain overflow, c1 flag, request and reset state,
   // c2 pin low, c33 last pin-low cycle, then counting again from a clear chain
   // the chain is held clear for the whole reset state, so no second timeout
   // can start inside a pulse
   always_comb begin
      next_state = state;
      next_por_cnt = por_cnt;
      case (state)
         wdt_pkg::WDT_ST_POR_WAIT: begin
            // chain stays idle until the power-on settle time has passed
            // the prescaler clear at the end of the wait comes through clr_pre
            if (por_done) begin
               next_state = wdt_pkg::WDT_ST_RUN; // R8
            end else begin
               next_por_cnt = por_cnt + 1'b1;
            end
         end
         wdt_pkg::WDT_ST_RUN: begin
            if (timeout) begin
               next_state = wdt_pkg::WDT_ST_RESET; // R2
            end
         end
         wdt_pkg::WDT_ST_RESET: begin
            // leave only once the stretcher has run out
            if (~pulse_active) begin
               next_state = wdt_pkg::WDT_ST_RUN;
            end
         end
         default: begin
            // an unknown code falls back to the power-on wait, the safe state
            next_state = wdt_pkg::WDT_ST_POR_WAIT;
         end
      endcase
   end

   // flags and pulses; a new timeout wins over a clear in the same cycle
   always_comb begin
      next_blank_monitor_off = blank_monitor_off;
      // blank-vector monitor entry latches; only the power-on reset releases it
      if (monitor_mode_in & ~monitor_via_irq_in) begin
         next_blank_monitor_off = 1'b1; // R13
      end
      next_cause_flag = cause_flag;
      if (cause_flag_clear_in) begin
         next_cause_flag = 1'b0;
      end
      if (timeout) begin
         next_cause_flag = 1'b1; // R6
      end
      // stop outcome: exactly one of the two pulses per executed stop instruction
      next_illegal = stop_exec_in & ~stop_enable_in; // R17 R18
      next_stop_entry = stop_exec_in & stop_enable_in; // R18
      // request follows the pin drive so the chip stays in reset throughout
      next_chip_req = timeout
         | (pulse_active & (next_state == wdt_pkg::WDT_ST_RESET)); // R2 R19
      // pin follows the stretcher only; it rises one cycle after the request and falls with it
      next_pin_low = pulse_active; // R6
   end

   // service read returns the vector byte, never watchdog state
   // data is zero outside a hit so the bus sees no stale vector byte
   // read and write share the location; a read never restarts the timeout
   always_comb begin
      next_rdata = '0;
      next_rdata_valid = svc_rd;
      if (svc_rd) begin
         next_rdata = reset_vector_low_in; // R5
      end
   end

   // registers only; the asynchronous reset branch loads constants alone, so
   // the power-on state is known before the first clock edge
   // pin_low rises one cycle after the request and falls in the same cycle as it, see the timeline above
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= wdt_pkg::WDT_ST_POR_WAIT;
         por_cnt <= '0;
         blank_monitor_off <= 1'b0;
         cause_flag <= 1'b0;
         rdata <= '0;
         rdata_valid <= 1'b0;
         illegal <= 1'b0;
         stop_entry <= 1'b0;
         chip_req <= 1'b0;
         pin_low <= 1'b0;
         cnt_q <= '0;
      end else begin
         state <= next_state;
         por_cnt <= next_por_cnt;
         blank_monitor_off <= next_blank_monitor_off;
         cause_flag <= next_cause_flag;
         rdata <= next_rdata;
         rdata_valid <= next_rdata_valid;
         illegal <= next_illegal;
         stop_entry <= next_stop_entry;
         chip_req <= next_chip_req;
         pin_low <= next_pin_low;
         cnt_q <= chain_count;
      end
   end

   // every output straight from a flip-flop; no interrupt output exists
   // count_out is the registered copy of the chain count, one cycle late
   // the only action of a timeout is a reset, never an interrupt request
   assign bus_rdata_out = rdata;
   assign bus_rdata_valid_out = rdata_valid;
   assign reset_pin_low_out = pin_low; // R6
   assign chip_reset_req_out = chip_req;
   assign watchdog_cause_flag_out = cause_flag;
   assign illegal_opcode_reset_out = illegal;
   assign stop_entry_out = stop_entry;
   assign count_out = cnt_q;
endmodule
`default_nettype wire

// >>> hdl/wdt_pkg.sv
// package for the watchdog reset timer: register offsets, widths, counts, states
// assumes clk_sys_in is the oscillator clock that the watchdog counts
`default_nettype none
package wdt_pkg;
   // bus map
   localparam logic [15:0] WDT_SERVICE_ADDR = 16'hffff; // watchdog_service location
   localparam int WDT_DATA_W = 8;
   localparam int WDT_ADDR_W = 16;
   // counting chain
   localparam int WDT_PRE_W = 12;
   localparam int WDT_CNT_W = 6;
   localparam int WDT_PRE_KEEP = 4; // stages 4..1 survive a service write
   localparam logic [WDT_CNT_W-1:0] WDT_CNT_LONG_LAST = 6'h3f; // 2^18 - 2^4 option
   localparam logic [WDT_CNT_W-1:0] WDT_CNT_SHORT_LAST = 6'h01; // 2^13 - 2^4 option
   localparam logic WDT_RATE_SHORT = 1'h1;
   // timing, in oscillator cycles, and the widths of the counters that time it
   localparam int WDT_RST_PIN_CYCLES = 32;
   localparam int WDT_POR_CLR_CYCLES = 4096;
   localparam int WDT_PULSE_W = 6;
   localparam int WDT_POR_W = 13;
   // top-level sequencing
   typedef enum logic [2:0] {
      WDT_ST_POR_WAIT = 3'h1,
      WDT_ST_RUN = 3'h2,
      WDT_ST_RESET = 3'h4
   } wdt_state_t;
endpackage
`default_nettype wire

// >>> hdl/wdt_chain.sv
// prescaler and timeout counter of the watchdog
// assumes clears are synchronous pulses or levels from the top module
`default_nettype none
module wdt_chain #(
   parameter int PRE_W = wdt_pkg::WDT_PRE_W,
   parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic rate_short_in,
   input wire logic clr_all_in,
   input wire logic clr_service_in,
   input wire logic clr_pre_in,
   output logic overflow_out,
   output logic [CNT_W-1:0] count_out
);
   logic [PRE_W-1:0] pre;
   logic [PRE_W-1:0] next_pre;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic next_overflow;
   logic carry;
   logic [CNT_W-1:0] last;

   // counter steps on the prescaler carry; overflow seen here, in the clock domain
   always_comb begin
      next_pre = pre;
      next_cnt = cnt;
      next_overflow = 1'b0;
      carry = &pre;
      last = rate_short_in ? wdt_pkg::WDT_CNT_SHORT_LAST : wdt_pkg::WDT_CNT_LONG_LAST; // R3
      if (clr_all_in) begin
         next_pre = '0; // R9
         next_cnt = '0; // R9
      end else if (run_in) begin
         next_pre = pre + 1'b1; // R1
         if (carry) begin
            next_cnt = cnt + 1'b1; // R20
            if (cnt == last) begin
               next_overflow = 1'b1; // R2 R20
               next_cnt = '0;
            end
         end
         // a service keeps the lowest stages so the period is 2^n less their value
         if (clr_service_in) begin
            next_cnt = '0; // R4
            next_pre = {{(PRE_W-wdt_pkg::WDT_PRE_KEEP){1'b0}},
               pre[wdt_pkg::WDT_PRE_KEEP-1:0]}; // R4
         end
         if (clr_pre_in) begin
            next_pre = '0;
         end
      end else begin
         if (clr_service_in) begin
            next_cnt = '0; // R4
            next_pre = {{(PRE_W-wdt_pkg::WDT_PRE_KEEP){1'b0}},
               pre[wdt_pkg::WDT_PRE_KEEP-1:0]};
         end
         if (clr_pre_in) begin
            next_pre = '0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pre <= '0;
         cnt <= '0;
         overflow_out <= 1'b0;
      end else begin
         pre <= next_pre;
         cnt <= next_cnt;
         overflow_out <= next_overflow;
      end
   end

   assign count_out = cnt;
endmodule
`default_nettype wire

// >>> hdl/wdt_pulse.sv
// stretches a one-cycle trigger into a fixed-length active pulse
// assumes trigger is a synchronous one-cycle pulse
`default_nettype none
module wdt_pulse #(
   parameter int LEN = wdt_pkg::WDT_RST_PIN_CYCLES,
   parameter int W = wdt_pkg::WDT_PULSE_W
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic trig_in,
   output logic active_out
);
   logic [W-1:0] left;
   logic [W-1:0] next_left;

   // retrigger while active restarts the full length
   always_comb begin
      next_left = left;
      if (trig_in) begin
         next_left = W'(LEN);
      end else if (left != '0) begin
         next_left = left - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         left <= '0;
      end else begin
         left <= next_left;
      end
   end

   assign active_out = (left != '0);
endmodule
`default_nettype wire

// >>> dv/wdt_top_props.sv
// checker on the watchdog top ports
// assumes one clock domain and an async active-high reset
`default_nettype none
module wdt_top_props #(
   parameter int RST_PIN_CYCLES = 32
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [15:0] bus_addr_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic [7:0] reset_vector_low_in,
   input wire logic [7:0] bus_rdata_out,
   input wire logic bus_rdata_valid_out,
   input wire logic watchdog_disable_in,
   input wire logic stop_enable_in,
   input wire logic stop_exec_in,
   input wire logic reset_pin_low_out,
   input wire logic chip_reset_req_out,
   input wire logic watchdog_cause_flag_out,
   input wire logic illegal_opcode_reset_out,
   input wire logic stop_entry_out,
   input wire logic [5:0] count_out
);
   int pin_cnt;
   // length of the current pin pulse, so a long pulse is caught as it happens
   always_ff @(posedge clk_sys_in or posedge rst_in)
      if (rst_in) pin_cnt <= 0;
      else pin_cnt <= reset_pin_low_out ? pin_cnt + 1 : 0;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   read_answer_a: assert property (
      bus_rd_in && bus_addr_in == 16'hffff |=> bus_rdata_valid_out
      && bus_rdata_out == $past(reset_vector_low_in)) else $error("read answer wrong");
   read_other_a: assert property (
      !(bus_rd_in && bus_addr_in == 16'hffff) |=> !bus_rdata_valid_out
      && bus_rdata_out == 8'h00) else $error("stray read data");
   service_clear_a: assert property (
      bus_wr_in && bus_addr_in == 16'hffff |-> ##2 count_out == 6'h00)
      else $error("service left count");
   pin_len_a: assert property (
      $fell(reset_pin_low_out) |-> pin_cnt == RST_PIN_CYCLES) else $error("pin pulse length");
   pin_max_a: assert property (
      pin_cnt <= RST_PIN_CYCLES) else $error("pin pulse too long");
   reset_cause_a: assert property (
      $rose(reset_pin_low_out) |-> watchdog_cause_flag_out && chip_reset_req_out)
      else $error("cause flag or request missing");
   stop_illegal_a: assert property (
      stop_exec_in && !stop_enable_in |=> illegal_opcode_reset_out && !stop_entry_out)
      else $error("illegal stop not flagged");
   stop_allowed_a: assert property (
      stop_exec_in && stop_enable_in |=> stop_entry_out && !illegal_opcode_reset_out)
      else $error("allowed stop not entered");
   disable_hold_a: assert property (
      watchdog_disable_in [*2] |=> count_out == 6'h00) else $error("count while disabled");
   count_step_a: assert property (
      $changed(count_out) |-> count_out == $past(count_out) + 6'h01 || count_out == 6'h00)
      else $error("count jumped");
   read_seen_c: cover property (bus_rd_in && bus_addr_in == 16'hffff);
   pin_seen_c: cover property ($rose(reset_pin_low_out));
   illegal_seen_c: cover property (illegal_opcode_reset_out);
endmodule
bind wdt_top wdt_top_props #(.RST_PIN_CYCLES(RST_PIN_CYCLES)) wdt_top_props_inst (
   .clk_sys_in, .rst_in, .bus_addr_in, .bus_wr_in, .bus_rd_in, .reset_vector_low_in,
   .bus_rdata_out, .bus_rdata_valid_out, .watchdog_disable_in, .stop_enable_in,
   .stop_exec_in, .reset_pin_low_out, .chip_reset_req_out, .watchdog_cause_flag_out,
   .illegal_opcode_reset_out, .stop_entry_out, .count_out);
`default_nettype wire

// >>> dv/wdt_cpu_model.sv
// cpu core model on the memory bus facing the watchdog
// assumes its task is called just after a falling clock edge
`default_nettype none
module wdt_cpu_model (
   input wire logic clk_sys_in,
   output logic [15:0] bus_addr_out,
   output logic bus_wr_out,
   output logic bus_rd_out,
   output logic [7:0] bus_wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      bus_addr_out = 16'h0000;
      bus_wr_out = 1'b0;
      bus_rd_out = 1'b0;
      bus_wdata_out = 8'h00;
   end
   // one access held over one rising edge; strobes then drop, released address and data are inverted so stale values mislead
   task automatic cyc(input logic wr, input logic rd, input logic [15:0] a);
      bus_addr_out = a;
      bus_wdata_out = a[7:0] ^ 8'h3c;
      bus_wr_out = wr;
      bus_rd_out = rd;
      @(negedge clk_sys_in);
      bus_wr_out = 1'b0;
      bus_rd_out = 1'b0;
      bus_addr_out = ~a;
      bus_wdata_out = ~bus_wdata_out;
   endtask
endmodule
`default_nettype wire

// >>> dv/watchdog_reset_timer_tb_top.sv
// testbench for the watchdog top: bus and stop table, timeout, disables
// assumes the checker is bound to the top and the power-on wait is shortened
`default_nettype none
module watchdog_reset_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, rate = 1'b1, dis = 1'b0, sten = 1'b0;
   logic sexec = 1'b0, smode = 1'b0, wmode = 1'b0, vf = 1'b0, irst = 1'b0, fclr = 1'b0;
   logic mon = 1'b0, mirq = 1'b0, itv = 1'b0, rtv = 1'b0, brk = 1'b0, hit;
   logic [7:0] vec = 8'ha7, wdata, rdata;
   logic [15:0] addr;
   logic wr, rd, valid, pin, req, flag, ill, sent;
   logic [5:0] cnt;
   int n_errors = 0, checks_done = 0, n;
   // rows: address, read, stop exec, stop enable, read valid expected
   logic [19:0] rows [6] = '{20'hffff9, 20'hfffe8, 20'hffff4, 20'hfffff, 20'h00008, 20'hffffb};
   // modes: long rate, stop mode, break, rst tv, irq tv, via irq, monitor, disable
   logic [7:0] modes [7] = '{8'h00, 8'h01, 8'h0e, 8'h16, 8'h30, 8'h80, 8'h40};
   initial forever #25 clk_sys_in = ~clk_sys_in;
   wdt_cpu_model cpu (.clk_sys_in(clk_sys_in), .bus_addr_out(addr), .bus_wr_out(wr),
      .bus_rd_out(rd), .bus_wdata_out(wdata));
   wdt_top #(.POR_CLR_CYCLES(16)) wdt_top_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd), .bus_wdata_in(wdata),
      .reset_vector_low_in(vec), .bus_rdata_out(rdata), .bus_rdata_valid_out(valid),
      .timeout_rate_select_in(rate), .watchdog_disable_in(dis), .stop_enable_in(sten),
      .stop_exec_in(sexec), .stop_mode_in(smode), .wait_mode_in(wmode),
      .vector_fetch_in(vf), .internal_reset_in(irst), .cause_flag_clear_in(fclr),
      .monitor_mode_in(mon), .monitor_via_irq_in(mirq), .irq_test_high_voltage_in(itv),
      .rst_pin_test_high_voltage_in(rtv), .break_active_in(brk), .reset_pin_low_out(pin),
      .chip_reset_req_out(req), .watchdog_cause_flag_out(flag),
      .illegal_opcode_reset_out(ill), .stop_entry_out(sent), .count_out(cnt));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // bounded wait for the pin; running out ends the run as a failure
   task automatic wait_pin(input int lim);
      n = 0;
      while (pin !== 1'b1) begin
         @(negedge clk_sys_in);
         n++;
         if (n > lim) begin
            n_errors++;
            summarize();
         end
      end
   endtask
   // run a stretch, noting any reset, optionally servicing every 3000 cycles;
   // offset so it never restarts a strobe that the caller has just released
   task automatic quiet(input int c, input bit svc);
      hit = 1'b0;
      for (int i = 0; i < c; i++) begin
         if (svc && i % 3000 == 1000) cpu.cyc(1'b1, 1'b0, 16'hffff);
         else @(negedge clk_sys_in);
         hit = hit | pin;
      end
   endtask
   initial begin
      repeat (20) @(negedge clk_sys_in);
      rst_in = 1'b0;
      chk("pin", pin, 1'b0);
      chk("flag", flag, 1'b0);
      chk("cnt", cnt, 6'h00);
      foreach (rows[i]) begin
         vec = 8'ha7 ^ 8'(i);
         sten = rows[i][1];
         sexec = rows[i][2];
         cpu.cyc(1'b0, rows[i][3], rows[i][19:4]);
         sexec = 1'b0;
         chk("valid", valid, rows[i][0]);
         chk("rdata", rdata, rows[i][0] ? vec : 8'h00);
         chk("illegal", ill, rows[i][2] & ~rows[i][1]);
         chk("stop", sent, rows[i][2] & rows[i][1]);
         @(negedge clk_sys_in);
      end
      // short timeout while waiting, from a fully cleared chain
      wmode = 1'b1;
      vf = 1'b1;
      cpu.cyc(1'b1, 1'b0, 16'hffff);
      vf = 1'b0;
      wait_pin(8300);
      chk("period", n > 8170 && n < 8200, 1'b1);
      chk("flag", flag, 1'b1);
      chk("req", req, 1'b1);
      n = 0;
      while (pin === 1'b1 && n < 40) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk("pin_len", 8'(n), 8'h20);
      fclr = 1'b1;
      @(negedge clk_sys_in);
      fclr = 1'b0;
      chk("flag_clr", flag, 1'b0);
      repeat (5000) @(negedge clk_sys_in);
      chk("cnt", cnt, 6'h01);
      irst = 1'b1;
      @(negedge clk_sys_in);
      irst = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      chk("cnt_irst", cnt, 6'h00);
      // each mode must keep the reset away past a short timeout
      wmode = 1'b0;
      for (int m = 0; m < 7; m++) begin
         {rate, smode, brk, rtv, itv, mirq, mon, dis} = modes[m] ^ 8'h80;
         cpu.cyc(1'b1, 1'b0, 16'hffff);
         quiet(9000, m == 0);
         chk("quiet", hit, 1'b0);
      end
      // blank-vector monitor entry stays disabled after monitor is left
      {rate, smode, brk, rtv, itv, mirq, mon, dis} = 8'h82;
      @(negedge clk_sys_in);
      mon = 1'b0;
      quiet(9000, 1'b0);
      chk("latched", hit, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
